//--- src/wwd_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock, 16-bit register port
// Notes:   included by the watchdog package and top module
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH

// register port geometry
`define WWD_ADDR_W        8
`define WWD_DATA_W        16

// register byte offsets
`define WWD_OFS_RESET_CONTROL_REG      8'h00
`define WWD_OFS_CFG       8'h04
`define WWD_OFS_STAT      8'h08
`define WWD_OFS_CNT       8'h0c

// reset_control_reg fields
`define WWD_RESET_CONTROL_REG_SWEN     5
`define WWD_RESET_CONTROL_REG_TO       4
`define WWD_RESET_CONTROL_REG_SLEEP    3
`define WWD_RESET_CONTROL_REG_IDLE     2

// watchdog_config_word fields
`define WWD_CFG_PS_LSB    0
`define WWD_CFG_PS_MSB    3
`define WWD_CFG_PSA       4
`define WWD_CFG_EN_LSB    5
`define WWD_CFG_EN_MSB    6
`define WWD_CFG_WINDOW_DISABLE_CFG    7
`define WWD_CFG_RST       16'h00d0

// enable_mode_cfg encodings
`define WWD_EN_ON         2'h3
`define WWD_EN_SW         2'h2
`define WWD_EN_OFF        2'h0

// prescaler terminal counts: divide by 32 or by 128
`define WWD_PRE32_LAST    7'h1f
`define WWD_PRE128_LAST   7'h7f
`define WWD_PRE32_SH      5'h05
`define WWD_PRE128_SH     5'h07

// low-power RC oscillator rate, emulated by a divider
`define WWD_CLK_HZ        100000000
`define WWD_LOW_POWER_RC_OSC_HZ       31000
`define WWD_LOW_POWER_RC_OSC_DIV      ((`WWD_CLK_HZ + `WWD_LOW_POWER_RC_OSC_HZ / 2) / `WWD_LOW_POWER_RC_OSC_HZ)

`endif

//--- src/wwd_pkg.sv
// Purpose: shared types of the windowed watchdog
// Assumes: constants come from wwd_cfg.svh
// Notes:   no logic here
`include "wwd_cfg.svh"

package wwd_pkg;

    // power state of the core as seen by the watchdog
    typedef enum logic [1:0] {
        PM_RUN,
        PM_SLEEP,
        PM_IDLE
    } wwd_pmode_e;

    // one-cycle instruction strobes from the core
    typedef struct packed {
        logic clear;        // watchdog_clear_instr executed
        logic sleep;        // power_save_instr, sleep flavour
        logic idle;         // power_save_instr, idle flavour
        logic osc_sw_done;  // oscillator switch completed
        logic wake;         // other wake source while powered down
    } wwd_core_s;

    // register port request
    typedef struct packed {
        logic [`WWD_ADDR_W-1:0] addr;
        logic [`WWD_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } wwd_bus_s;

endpackage : wwd_pkg

//--- src/wwd_top.sv
// Purpose: windowed watchdog timer on an emulated low-power RC clock
// Assumes: core strobes and register port are on sys_clk_i
// Notes:   all slower rates are enable pulses from one divider
//
// Functional notes
// R1 - watchdog counts on RC oscillator, enable starts it
// R2 - prescaler divides by 32 or 128
// R3 - base period nominally 1 ms or 4 ms
// R4 - postscaler ratios 1:1 to 1:32768, sixteen settings
// R5 - device reset clears all counts
// R6 - oscillator switch completion restarts all counts
// R7 - entering sleep or idle clears counts
// R8 - leaving sleep or idle clears counts
// R9 - clear instruction restarts counts in normal running
// R10 - watchdog keeps counting in sleep and idle
// R11 - time-out in sleep or idle wakes, not resets
// R12 - software clears sleep and idle flags itself
// R13 - time-out flag sticky until software clears it
// R14 - window mode accepts clear only in final quarter
// R15 - early clear in window mode causes reset
// R16 - window mode when window disable bit is zero
// R17 - enable field: 11 on, 10 software, 00 off
// R18 - software enable bit starts and stops watchdog
// R19 - device reset clears software enable bit
// R20 - terminal count while running resets, sets flag
// R21 - window opens past three quarters, restarts close it
`include "wwd_cfg.svh"

module wwd_top (
    input  wire logic                   sys_clk_i,  // system clock
    input  wire logic                   nrst_i,     // async reset, low
    input  wire wwd_pkg::wwd_bus_s      bus_i,      // register request
    input  wire wwd_pkg::wwd_core_s     core_i,     // core strobes
    output logic [`WWD_DATA_W-1:0]      rd_data_o,  // read data, +1 cycle
    output logic                        low_power_rc_osc_en_o,  // RC osc enable
    output logic                        wdt_rst_o,  // device reset pulse
    output logic                        wake_o      // wake pulse
);

    // postscaler terminal count for a ratio of 2**ps
    function automatic logic [14:0] post_last_f(input logic [3:0] ps);
        post_last_f = 15'h7fff >> (4'hf - ps);
    endfunction

    // elapsed count at which the final quarter begins
    function automatic logic [22:0] win_thr_f(input logic [3:0] ps,
                                              input logic       psa);
        logic [4:0] sh;
        sh = 5'(ps) + (psa ? (`WWD_PRE128_SH - 5'h02)
                           : (`WWD_PRE32_SH - 5'h02));
        win_thr_f = 23'h000003 << sh;
    endfunction

    logic [`WWD_DATA_W-1:0] cfg_reg;
    logic                   swen_reg;
    logic                   to_flag_reg;
    logic                   sleep_flag_reg;
    logic                   idle_flag_reg;
    wwd_pkg::wwd_pmode_e    pmode_reg;
    logic [11:0]            div_reg;
    logic [6:0]             pre_reg;
    logic [14:0]            post_reg;

    logic [3:0]  ps_sel;
    logic        psa_sel;
    logic [1:0]  en_mode;
    logic        window_disable_cfg;
    logic        enabled;
    logic        low_power_rc_osc_tick;
    logic [6:0]  pre_last;
    logic        timeout;
    logic [21:0] elapsed;
    logic        window_open;
    logic        clr_ok;
    logic        early_clr;
    logic        enter_ps;
    logic        exit_ps;
    logic        wdt_fire;
    logic        restart;
    logic        reset_control_reg_wr;
    logic        cfg_wr;

    // configuration fields
    assign ps_sel  = cfg_reg[`WWD_CFG_PS_MSB:`WWD_CFG_PS_LSB];      // R4
    assign psa_sel = cfg_reg[`WWD_CFG_PSA];                         // R2
    assign en_mode = cfg_reg[`WWD_CFG_EN_MSB:`WWD_CFG_EN_LSB];
    assign window_disable_cfg  = cfg_reg[`WWD_CFG_WINDOW_DISABLE_CFG];

    // code 01 is undefined and treated as off, the power-saving choice
    assign enabled = (en_mode == `WWD_EN_ON) ||
                     ((en_mode == `WWD_EN_SW) && swen_reg);         // R17 R18

    // one tick per RC period, 31 kHz nominal: 32 ticks ~1 ms, 128 ~4 ms
    assign low_power_rc_osc_tick = enabled &&
                       (div_reg == 12'(`WWD_LOW_POWER_RC_OSC_DIV - 1));         // R1 R3
    assign pre_last  = psa_sel ? `WWD_PRE128_LAST : `WWD_PRE32_LAST; // R2
    assign timeout   = low_power_rc_osc_tick && (pre_reg == pre_last) &&
                       (post_reg == post_last_f(ps_sel));           // R4

    // elapsed RC ticks of the current period
    assign elapsed = psa_sel ? {post_reg, pre_reg}
                             : {2'h0, post_reg, pre_reg[4:0]};
    assign window_open = window_disable_cfg ||                                  // R16
                         ({1'b0, elapsed} >=
                          win_thr_f(ps_sel, psa_sel));              // R21

    // core events qualified by power state
    assign clr_ok    = core_i.clear && (pmode_reg == wwd_pkg::PM_RUN) &&
                       enabled;                                     // R9
    assign early_clr = clr_ok && !window_open;                      // R15
    assign enter_ps  = (pmode_reg == wwd_pkg::PM_RUN) &&
                       (core_i.sleep || core_i.idle);
    assign exit_ps   = (pmode_reg != wwd_pkg::PM_RUN) &&
                       (core_i.wake || timeout);                    // R11
    assign wdt_fire  = (pmode_reg == wwd_pkg::PM_RUN) &&
                       (timeout || early_clr);                      // R20 R15

    // a disabled watchdog sits at zero so re-enabling starts fresh;
    // a config write restarts too, so no count sits past a new terminal
    assign restart = core_i.osc_sw_done ||                          // R6
                     enter_ps || exit_ps ||                         // R7 R8
                     clr_ok || wdt_fire ||                          // R9 R14
                     !enabled || cfg_wr;

    assign reset_control_reg_wr = bus_i.wr && (bus_i.addr == `WWD_OFS_RESET_CONTROL_REG);
    assign cfg_wr  = bus_i.wr && (bus_i.addr == `WWD_OFS_CFG);

    // configuration word, software writable here
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cfg_reg <= `WWD_CFG_RST;
        else if (cfg_wr)
            cfg_reg <= {8'h00, bus_i.wdata[7:0]};
    end

    // software enable; a watchdog reset counts as a device reset
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            swen_reg <= 1'b0;                                       // R19
        else if (wdt_fire)
            swen_reg <= 1'b0;                                       // R19
        else if (reset_control_reg_wr)
            swen_reg <= bus_i.wdata[`WWD_RESET_CONTROL_REG_SWEN];                // R18
    end

    // sticky time-out flag: a set in the clearing cycle wins
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            to_flag_reg <= 1'b0;
        else if (timeout || early_clr)
            to_flag_reg <= 1'b1;                                    // R13 R20
        else if (reset_control_reg_wr)
            to_flag_reg <= bus_i.wdata[`WWD_RESET_CONTROL_REG_TO];               // R13
    end

    // power-save flags, left set on wake for software to clear
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sleep_flag_reg <= 1'b0;
            idle_flag_reg  <= 1'b0;
        end
        else
        begin
            if (enter_ps && core_i.sleep)
                sleep_flag_reg <= 1'b1;
            else if (reset_control_reg_wr)
                sleep_flag_reg <= bus_i.wdata[`WWD_RESET_CONTROL_REG_SLEEP];     // R12
            if (enter_ps && !core_i.sleep)
                idle_flag_reg <= 1'b1;
            else if (reset_control_reg_wr)
                idle_flag_reg <= bus_i.wdata[`WWD_RESET_CONTROL_REG_IDLE];       // R12
        end
    end

    // power state tracking; sleep wins if both strobes arrive
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pmode_reg <= wwd_pkg::PM_RUN;
        else if (wdt_fire || exit_ps)
            pmode_reg <= wwd_pkg::PM_RUN;                           // R11
        else if (enter_ps)
            pmode_reg <= core_i.sleep ? wwd_pkg::PM_SLEEP
                                      : wwd_pkg::PM_IDLE;
    end

    // divider, prescaler and postscaler; keep running in power-down
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_reg  <= 12'h000;                                    // R5
            pre_reg  <= 7'h00;
            post_reg <= 15'h0000;
        end
        else if (restart)
        begin
            div_reg  <= 12'h000;                                    // R6 R7 R8
            pre_reg  <= 7'h00;                                      // R9 R21
            post_reg <= 15'h0000;
        end
        else if (low_power_rc_osc_tick)
        begin
            div_reg <= 12'h000;                                     // R10
            if (pre_reg == pre_last)
            begin
                pre_reg  <= 7'h00;
                post_reg <= post_reg + 15'h0001;                    // R4
            end
            else
                pre_reg <= pre_reg + 7'h01;                         // R2
        end
        else
            div_reg <= div_reg + 12'h001;                           // R10
    end

    // event outputs, registered
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wdt_rst_o <= 1'b0;
            wake_o    <= 1'b0;
            low_power_rc_osc_en_o <= 1'b0;
        end
        else
        begin
            wdt_rst_o <= wdt_fire;                                  // R20 R15
            wake_o    <= timeout && (pmode_reg != wwd_pkg::PM_RUN); // R11
            low_power_rc_osc_en_o <= enabled;                                   // R1
        end
    end

    // read port; unmapped addresses return zero
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rd_data_o <= '0;
        else if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                `WWD_OFS_RESET_CONTROL_REG: rd_data_o <= {10'h000, swen_reg,
                                             to_flag_reg, sleep_flag_reg,
                                             idle_flag_reg, 2'h0};
                `WWD_OFS_CFG:  rd_data_o <= cfg_reg;
                `WWD_OFS_STAT: rd_data_o <= {12'h000,
                                             pmode_reg == wwd_pkg::PM_IDLE,
                                             pmode_reg == wwd_pkg::PM_SLEEP,
                                             window_open, enabled};
                `WWD_OFS_CNT:  rd_data_o <= {1'b0, post_reg};
                default:       rd_data_o <= '0;
            endcase
        end
        else
            rd_data_o <= '0;
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    property p_osc_on;
        enabled |=> low_power_rc_osc_en_o;
    endproperty
    a_osc_on: assert property (p_osc_on) // R1
        else $error("rc oscillator not enabled");

    property p_pre_bound;
        pre_reg <= pre_last;
    endproperty
    a_pre_bound: assert property (p_pre_bound) // R2
        else $error("prescaler past terminal count");

    property p_osc_sw;
        core_i.osc_sw_done |=> (pre_reg == 7'h00) && (post_reg == 15'h0000)
                               && (div_reg == 12'h000);
    endproperty
    a_osc_sw: assert property (p_osc_sw) // R6
        else $error("clock switch did not restart counts");

    property p_enter_ps;
        enter_ps |=> (post_reg == 15'h0000) && (pre_reg == 7'h00) &&
                     (sleep_flag_reg || idle_flag_reg);
    endproperty
    a_enter_ps: assert property (p_enter_ps) // R7
        else $error("power-save entry did not clear counts");

    property p_exit_ps;
        exit_ps |=> (pmode_reg == wwd_pkg::PM_RUN) && (pre_reg == 7'h00);
    endproperty
    a_exit_ps: assert property (p_exit_ps) // R8
        else $error("power-save exit did not clear counts");

    property p_clear;
        (clr_ok && window_open && !timeout)
            |=> !wdt_rst_o && (div_reg == 12'h000) &&
                (post_reg == 15'h0000);
    endproperty
    a_clear: assert property (p_clear) // R9
        else $error("accepted clear did not restart");

    property p_ps_runs;
        (pmode_reg != wwd_pkg::PM_RUN && enabled && !restart)
            |=> div_reg != $past(div_reg);
    endproperty
    a_ps_runs: assert property (p_ps_runs) // R10
        else $error("watchdog stalled in power-save");

    property p_wake;
        (timeout && pmode_reg != wwd_pkg::PM_RUN)
            |=> wake_o && !wdt_rst_o && pmode_reg == wwd_pkg::PM_RUN;
    endproperty
    a_wake: assert property (p_wake) // R11
        else $error("power-save time-out did not wake");

    property p_flag_sticky;
        (to_flag_reg && !reset_control_reg_wr) |=> to_flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R13
        else $error("time-out flag dropped");

    property p_early;
        early_clr |=> wdt_rst_o && to_flag_reg && (post_reg == 15'h0000);
    endproperty
    a_early: assert property (p_early) // R15
        else $error("early clear missed reset");

    property p_window_disable_cfg;
        (window_disable_cfg && clr_ok && !timeout) |=> !wdt_rst_o;
    endproperty
    a_window_disable_cfg: assert property (p_window_disable_cfg) // R16
        else $error("window active while disabled");

    property p_off;
        (en_mode == `WWD_EN_OFF) |=> !low_power_rc_osc_en_o && (pre_reg == 7'h00);
    endproperty
    a_off: assert property (p_off) // R17
        else $error("watchdog runs in off mode");

    property p_swen_clr;
        wdt_fire |=> !swen_reg;
    endproperty
    a_swen_clr: assert property (p_swen_clr) // R19
        else $error("software enable survived reset");

    property p_run_timeout;
        (timeout && pmode_reg == wwd_pkg::PM_RUN)
            |=> wdt_rst_o && to_flag_reg && !wake_o;
    endproperty
    a_run_timeout: assert property (p_run_timeout) // R20
        else $error("time-out did not reset");

endmodule // wwd_top

//--- verif/wwd_core_model.sv
// Purpose: processor core stand-in that issues watchdog instruction strobes
// Assumes: the bench sends one request at a time on sys_clk_i
// Notes:   each strobe leaves one cycle after its request
module wwd_core_model (
    input  wire logic               sys_clk_i,  // system clock
    input  wire logic               nrst_i,     // async reset, low
    input  wire logic               go_i,       // request pulse
    input  wire logic [2:0]         op_i,       // 0 clr 1 slp 2 idl 3 osc 4 wk
    input  wire logic               wake_i,     // watchdog wake pulse
    input  wire logic               rst_i,      // watchdog reset pulse
    output wwd_pkg::wwd_core_s      core_o,     // instruction strobes
    output logic                    asleep_o    // core powered down
);
    timeunit 1ns;
    timeprecision 1ps;

    // a powered-down core executes no clear, and wakes only when asleep
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            core_o <= '0;
        end
        else
        begin
            core_o.clear       <= go_i && op_i == 3'h0 && !asleep_o;
            core_o.sleep       <= go_i && op_i == 3'h1;
            core_o.idle        <= go_i && op_i == 3'h2;
            core_o.osc_sw_done <= go_i && op_i == 3'h3;
            core_o.wake        <= go_i && op_i == 3'h4 && asleep_o;
        end
    end

    // power state follows the strobes and the watchdog's wake or reset
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            asleep_o <= 1'b0;
        else if (wake_i || rst_i || core_o.wake)
            asleep_o <= 1'b0;
        else if (core_o.sleep || core_o.idle)
            asleep_o <= 1'b1;
    end
endmodule // wwd_core_model

//--- verif/wwd_top_tb.sv
// Purpose: self-checking bench of the windowed watchdog
// Assumes: 100 MHz clock, config 0x00e0 or 0x0060 with /32 and 1:1
// Notes:   one full time-out in sleep takes about 103k cycles
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end

module wwd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [7:0]  wa;
        logic [15:0] wd;
        logic [7:0]  ra;
        logic [15:0] exp;
    } wwd_row_s;

    logic               sys_clk_i;
    logic               nrst_i;
    wwd_pkg::wwd_bus_s  bus;
    wwd_pkg::wwd_core_s core;
    logic [15:0]        rd_data;
    logic               low_power_rc_osc_en;
    logic               wdt_rst;
    logic               wake;
    logic               go;
    logic [2:0]         op_s;
    logic               asleep;
    int                 fail_count;
    int                 compares;
    int                 cycles;
    int                 rst_cnt;
    int                 rst_seen;
    bit                 hit;
    logic [15:0]        d;
    // write, then read back: register behaviour and enable modes
    wwd_row_s rows [12] = '{
        '{8'h00, 16'h0020, 8'h00, 16'h0020},
        '{8'h00, 16'h0020, 8'h08, 16'h0003},
        '{8'h04, 16'h0080, 8'h08, 16'h0002},
        '{8'h04, 16'h00a0, 8'h08, 16'h0002},
        '{8'h04, 16'h00e0, 8'h08, 16'h0003},
        '{8'h04, 16'h00c0, 8'h08, 16'h0003},
        '{8'h00, 16'h0000, 8'h08, 16'h0002},
        '{8'h04, 16'h00e0, 8'h08, 16'h0003},
        '{8'h04, 16'hffe0, 8'h04, 16'h00e0},
        '{8'h10, 16'hffff, 8'h10, 16'h0000},
        '{8'h08, 16'hffff, 8'h08, 16'h0003},
        '{8'h0c, 16'hffff, 8'h0c, 16'h0000}};

    wwd_top u_dut (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .bus_i     (bus),
        .core_i    (core),
        .rd_data_o (rd_data),
        .low_power_rc_osc_en_o (low_power_rc_osc_en),
        .wdt_rst_o (wdt_rst),
        .wake_o    (wake)
    );

    wwd_core_model u_core (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .go_i      (go),
        .op_i      (op_s),
        .wake_i    (wake),
        .rst_i     (wdt_rst),
        .core_o    (core),
        .asleep_o  (asleep)
    );

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // cut a hang short; also count reset pulses for the sleep test
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (wdt_rst === 1'b1)
            rst_cnt++;
        if (cycles == 110000)
        begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic end_sim();
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge sys_clk_i);
        bus.wr    <= 1'b0;
    endtask

    // data stand in the cycle after the strobe; take them at its end
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] v);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge sys_clk_i);
        bus.rd   <= 1'b0;
        @(posedge sys_clk_i);
        v = rd_data;
    endtask

    // returns at the edge where the watchdog takes the strobe
    task automatic core_op(input logic [2:0] o);
        go   <= 1'b1;
        op_s <= o;
        @(posedge sys_clk_i);
        go   <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wait_evt(input bit w, input int lim, output bit h);
        h = 1'b0;
        repeat (lim)
        begin
            @(posedge sys_clk_i);
            if ((w ? wake : wdt_rst) === 1'b1)
            begin
                h = 1'b1;
                break;
            end
        end
    endtask

    // main sequence: reset, table, then the awkward cases
    initial
    begin
        nrst_i = 1'b0;
        bus    = '0;
        go     = 1'b0;
        op_s   = 3'h0;
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_rd(8'h04, d);
        `CHK(d, 16'h00d0)
        bus_rd(8'h00, d);
        `CHK(d, 16'h0000)
        foreach (rows[i])
        begin
            bus_wr(rows[i].wa, rows[i].wd);
            bus_rd(rows[i].ra, d);
            `CHK(d, rows[i].exp)
            if (rows[i].ra == 8'h08)
                `CHK(low_power_rc_osc_en, rows[i].exp[0])
        end
        // window off: a clear at any time is harmless
        core_op(3'h0);
        wait_evt(1'b0, 8, hit);
        `CHK(hit, 1'b0)
        // sleep: must not wake before one /32 period, then must wake
        rst_seen = rst_cnt;
        core_op(3'h1);
        wait_evt(1'b1, 103000, hit);
        `CHK(hit, 1'b0)
        wait_evt(1'b1, 600, hit);
        `CHK(hit, 1'b1)
        `CHK(rst_cnt, rst_seen)
        bus_rd(8'h00, d);
        `CHK(d, 16'h0018)
        bus_wr(8'h00, 16'h0000);
        bus_rd(8'h00, d);
        `CHK(d, 16'h0000)
        // power-down status and the external wake, both flavours
        core_op(3'h1);
        bus_rd(8'h08, d);
        `CHK(d, 16'h0007)
        core_op(3'h4);
        core_op(3'h2);
        bus_rd(8'h08, d);
        `CHK(d, 16'h000b)
        core_op(3'h4);
        core_op(3'h3);
        bus_rd(8'h08, d);
        `CHK(d, 16'h0003)
        // window on: a clear long before the last quarter resets
        bus_wr(8'h04, 16'h0060);
        core_op(3'h0);
        wait_evt(1'b0, 8, hit);
        `CHK(hit, 1'b1)
        bus_rd(8'h00, d);
        `CHK(d, 16'h001c)
        // second reset in mid-run drops the software enable
        bus_wr(8'h00, 16'h0020);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_rd(8'h00, d);
        `CHK(d, 16'h0000)
        `CHK(low_power_rc_osc_en, 1'b0)
        end_sim();
    end
endmodule // wwd_top_tb
